// ---- modbus_tcp_server_framer.sv ----
// Purpose: Parse MODBUS TCP requests, hand commands to the memory side, build responses.
// Assumes: Request and response streams come from logic on clk; config pins are asynchronous.
// Notes: Receive and read-data ready are paced one byte per two cycles to keep them registered.
`timescale 1ns/1ps
module modbus_tcp_server_framer
	import modbus_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request byte stream
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	// Response byte stream
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	// Configuration pins
	input wire logic client_mode_pin,
	input wire logic alt_addr_pin,
	// Memory command
	output logic cmd_valid,
	input wire logic cmd_ready,
	output logic [7:0] cmd_func,
	output space_t cmd_space,
	output logic [15:0] cmd_addr,
	output logic [15:0] cmd_word,
	output logic [7:0] cmd_unit,
	// Write payload for multiple writes
	output logic wr_valid,
	output logic [7:0] wr_data,
	input wire logic wr_ready,
	// Command completion
	input wire logic done_valid,
	input wire logic done_error,
	input wire logic [7:0] done_excode,
	input wire logic [7:0] done_count,
	// Read data
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output logic rd_ready,
	// Client request filter
	input wire logic cl_req_valid,
	input wire logic [7:0] cl_req_func,
	output logic cl_grant,
	output logic cl_refuse
);
	frame_state_t state_q;
	logic [2:0] hdr_idx_q;
	logic [15:0] tid_q;
	logic [15:0] pid_q;
	logic [15:0] len_q;
	logic [7:0] unit_q;
	logic [7:0] func_q;
	logic [15:0] addr_q;
	logic [15:0] word_q;
	logic [7:0] bcnt_q;
	logic [8:0] didx_q;
	logic [15:0] rem_q;
	logic drop_q;
	logic [7:0] exc_q;
	logic [15:0] rsp_len_q;
	logic [7:0] rd_cnt_q;
	logic [7:0] rd_rem_q;
	logic [3:0] tx_idx_q;
	logic rx_ready_q;
	logic rd_ready_q;
	logic cmd_valid_q;
	space_t cmd_space_q;
	logic wr_valid_q;
	logic [7:0] wr_data_q;
	logic cl_grant_q;
	logic cl_refuse_q;
	logic [1:0] cfg_meta_q;
	logic [1:0] cfg_q;

	logic rx_take;
	logic rd_take;
	logic wr_push;
	logic in_rx;
	logic is_exc;
	logic b_valid;
	logic b_ready;
	logic [7:0] b_byte;
	logic b_last;
	logic b_push;
	logic [FIFO_WIDTH-1:0] out_word;

	assign rx_take = rx_valid && rx_ready_q;
	assign rd_take = rd_valid && rd_ready_q;
	assign in_rx = (state_q == ST_HDR) || (state_q == ST_FUNC) || (state_q == ST_DATA) || (state_q == ST_SKIP);
	assign is_exc = exc_q != EXC_NONE;
	assign wr_push = rx_take && (state_q == ST_DATA) && func_is_multi(func_q) && (didx_q > DATA_BCNT_IDX);

	// Config pins are static straps but may toggle at any time
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cfg_meta_q <= RST_CFG;
			cfg_q <= RST_CFG;
		end
		else
		begin
			cfg_meta_q <= {alt_addr_pin, client_mode_pin};
			cfg_q <= cfg_meta_q;
		end
	end

	// Frame sequencer
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_q <= ST_HDR;
			hdr_idx_q <= HDR_IDX_RST;
			tid_q <= RST_WORD;
			pid_q <= RST_WORD;
			len_q <= RST_WORD;
			unit_q <= RST_BYTE;
			func_q <= FC_NONE;
			addr_q <= RST_WORD;
			word_q <= RST_WORD;
			bcnt_q <= RST_BYTE;
			didx_q <= DIDX_RST;
			rem_q <= RST_WORD;
			drop_q <= 1'b0;
			exc_q <= EXC_NONE;
			rsp_len_q <= RST_WORD;
			rd_cnt_q <= RST_BYTE;
			rd_rem_q <= RST_BYTE;
			tx_idx_q <= TX_IDX_RST;
		end
		else
		begin
			case (state_q)
				ST_HDR:
				if (rx_take)
				begin
					hdr_idx_q <= hdr_idx_q + 3'h1;
					case (hdr_idx_q)
						3'h0: tid_q[15:8] <= rx_data;
						3'h1: tid_q[7:0] <= rx_data;
						3'h2: pid_q[15:8] <= rx_data;
						3'h3: pid_q[7:0] <= rx_data;
						3'h4: len_q[15:8] <= rx_data;
						3'h5: len_q[7:0] <= rx_data;
						default:
						begin
							unit_q <= rx_data;
							hdr_idx_q <= HDR_IDX_RST;
							// Foreign protocol or runt length: swallow silently
							if (pid_q != PROTO_ID || len_q < LEN_MIN)
							begin
								drop_q <= 1'b1;
								rem_q <= len_q - ONE_W;
								state_q <= (len_q > ONE_W) ? ST_SKIP : ST_HDR;
							end
							else
							begin
								drop_q <= 1'b0;
								state_q <= ST_FUNC;
							end
						end
					endcase
				end
				ST_FUNC:
				if (rx_take)
				begin
					func_q <= rx_data;
					didx_q <= DIDX_RST;
					rem_q <= len_q - LEN_MIN;
					if (!func_server_ok(rx_data))
					begin
						exc_q <= EXC_ILL_FUNC;
						state_q <= (len_q > LEN_MIN) ? ST_SKIP : ST_RSP;
					end
					else if (func_is_multi(rx_data) ? (len_q < LEN_MULTI_MIN) : (len_q != LEN_FIXED))
					begin
						exc_q <= EXC_ILL_VALUE;
						state_q <= (len_q > LEN_MIN) ? ST_SKIP : ST_RSP;
					end
					else
					begin
						exc_q <= EXC_NONE;
						state_q <= ST_DATA;
					end
				end
				ST_DATA:
				if (rx_take)
				begin
					didx_q <= didx_q + 9'h001;
					case (didx_q)
						9'h000: addr_q[15:8] <= rx_data;
						9'h001: addr_q[7:0] <= rx_data;
						9'h002: word_q[15:8] <= rx_data;
						9'h003: word_q[7:0] <= rx_data;
						9'h004: bcnt_q <= rx_data;
						default: ;
					endcase
					if (!func_is_multi(func_q))
					begin
						if (didx_q == DATA_FIXED_LAST)
							state_q <= (func_q == FC_LOOPBACK) ? ST_RSP : ST_CMD;
					end
					else if (didx_q == DATA_BCNT_IDX)
					begin
						// Byte count must agree with the header length
						if (len_q != ({8'h00, rx_data} + LEN_MULTI_MIN))
						begin
							exc_q <= EXC_ILL_VALUE;
							rem_q <= len_q - LEN_MULTI_MIN;
							state_q <= (len_q > LEN_MULTI_MIN) ? ST_SKIP : ST_RSP;
						end
						else if (rx_data == RST_BYTE)
							state_q <= ST_CMD;
					end
					else if (didx_q == ({1'b0, bcnt_q} + DATA_BCNT_IDX))
						state_q <= ST_CMD;
				end
				ST_SKIP:
				if (rx_take)
				begin
					rem_q <= rem_q - ONE_W;
					if (rem_q == ONE_W)
						state_q <= drop_q ? ST_HDR : ST_RSP;
				end
				ST_CMD:
				if (cmd_valid_q && cmd_ready)
					state_q <= ST_WAIT;
				ST_WAIT:
				if (done_valid)
				begin
					rd_cnt_q <= done_count;
					if (done_error)
						exc_q <= (done_excode == EXC_NONE) ? EXC_DEV_FAIL : done_excode;
					state_q <= ST_RSP;
				end
				ST_RSP:
				begin
					tx_idx_q <= TX_IDX_RST;
					rd_rem_q <= rd_cnt_q;
					if (is_exc)
						rsp_len_q <= LEN_EXC;
					else if (func_is_read(func_q))
						rsp_len_q <= LEN_READ_BASE + {8'h00, rd_cnt_q};
					else
						rsp_len_q <= LEN_ECHO;
					state_q <= ST_TX;
				end
				ST_TX:
				if (b_push)
				begin
					tx_idx_q <= tx_idx_q + 4'h1;
					if (b_last)
						state_q <= ST_HDR;
					else if (tx_idx_q == TX_IDX_PAY && func_is_read(func_q))
						state_q <= ST_TXRD;
				end
				ST_TXRD:
				if (rd_take)
				begin
					rd_rem_q <= rd_rem_q - 8'h01;
					if (rd_rem_q == 8'h01)
						state_q <= ST_HDR;
				end
				default: state_q <= ST_HDR;
			endcase
		end
	end

	// Response byte selection
	always_comb
	begin
		b_valid = 1'b0;
		b_byte = RST_BYTE;
		b_last = 1'b0;
		if (state_q == ST_TX)
		begin
			b_valid = 1'b1;
			case (tx_idx_q)
				4'h0: b_byte = tid_q[15:8];
				4'h1: b_byte = tid_q[7:0];
				4'h2: b_byte = PROTO_ID[15:8];
				4'h3: b_byte = PROTO_ID[7:0];
				4'h4: b_byte = rsp_len_q[15:8];
				4'h5: b_byte = rsp_len_q[7:0];
				4'h6: b_byte = unit_q;
				TX_IDX_FUNC: b_byte = is_exc ? (func_q | EXC_BIT) : func_q;
				TX_IDX_PAY: b_byte = is_exc ? exc_q : (func_is_read(func_q) ? rd_cnt_q : addr_q[15:8]);
				4'h9: b_byte = addr_q[7:0];
				4'ha: b_byte = word_q[15:8];
				default: b_byte = word_q[7:0];
			endcase
			b_last = (tx_idx_q == TX_IDX_PAY && (is_exc || (func_is_read(func_q) && rd_cnt_q == RST_BYTE))) ||
				(tx_idx_q == TX_IDX_LAST);
		end
		else if (state_q == ST_TXRD)
		begin
			b_valid = rd_take;
			b_byte = rd_data;
			b_last = rd_rem_q == 8'h01;
		end
	end

	assign b_push = b_valid && b_ready;

	// Ready held until taken; re-armed only when the next stage has room
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rx_ready_q <= 1'b0;
			rd_ready_q <= 1'b0;
		end
		else
		begin
			rx_ready_q <= in_rx && (rx_ready_q ? !rx_take : !(wr_valid_q && !wr_ready));
			rd_ready_q <= (state_q == ST_TXRD) && (rd_ready_q ? !rd_take : b_ready);
		end
	end

	// Command and write payload
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cmd_valid_q <= 1'b0;
			cmd_space_q <= SP_COILS;
			wr_valid_q <= 1'b0;
			wr_data_q <= RST_BYTE;
		end
		else
		begin
			cmd_valid_q <= (state_q == ST_CMD) && !(cmd_valid_q && cmd_ready);
			cmd_space_q <= space_of(func_q, cfg_q[1]);
			if (wr_push)
			begin
				wr_valid_q <= 1'b1;
				wr_data_q <= rx_data;
			end
			else if (wr_ready)
				wr_valid_q <= 1'b0;
		end
	end

	// Outgoing requests in client mode pass only the allowed codes
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cl_grant_q <= 1'b0;
			cl_refuse_q <= 1'b0;
		end
		else
		begin
			cl_grant_q <= cl_req_valid && cfg_q[0] && func_client_ok(cl_req_func);
			cl_refuse_q <= cl_req_valid && !(cfg_q[0] && func_client_ok(cl_req_func));
		end
	end

	frame_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(b_valid),
		.in_ready(b_ready),
		.in_data({b_last, b_byte}),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(out_word)
	);

	assign tx_data = out_word[7:0];
	assign tx_last = out_word[8];
	assign rx_ready = rx_ready_q;
	assign rd_ready = rd_ready_q;
	assign cmd_valid = cmd_valid_q;
	assign cmd_func = func_q;
	assign cmd_space = cmd_space_q;
	assign cmd_addr = addr_q;
	assign cmd_word = word_q;
	assign cmd_unit = unit_q;
	assign wr_valid = wr_valid_q;
	assign wr_data = wr_data_q;
	assign cl_grant = cl_grant_q;
	assign cl_refuse = cl_refuse_q;
endmodule : modbus_tcp_server_framer

// ---- modbus_pkg.sv ----
// Purpose: Shared constants, types and decoders for the MODBUS TCP server framer.
// Assumes: Byte streams arrive most significant byte first, one byte per handshake.
// Notes: Behaviour
// Behaviour
// - Seven-byte header, then function code, then data
// - Response repeats the request transaction identifier
// - Protocol identifier is zero both ways
// - Length counts unit, function and data bytes
// - Unit identifier returned unchanged
// - Function code is eight bits, one to 255
// - Success echoes the request function code
// - Error sets function code top bit
// - Exception carries exception code, normal carries data
// - Data field is plain bytes, may be absent
// - Completion from function code or byte count
// - Server executes codes 1-6, 8, 15, 16
// - Client issues only 1, 2, 3, 6, 15, 16
// - Alternate addressing maps 3/4 to analog registers
// - Requests served without host controller program
package modbus_pkg;

	typedef enum logic [3:0] {ST_HDR, ST_FUNC, ST_DATA, ST_SKIP, ST_CMD, ST_WAIT, ST_RSP, ST_TX, ST_TXRD} frame_state_t;
	typedef enum logic [2:0] {SP_COILS, SP_DISCRETES, SP_HOLDING, SP_INPUT_REGS, SP_ANALOG_OUT, SP_ANALOG_IN} space_t;

	localparam int HDR_BYTES = 7;
	localparam logic [2:0] HDR_LAST = 3'(HDR_BYTES - 1);
	localparam logic [2:0] HDR_IDX_RST = 3'h0;
	localparam logic [15:0] PROTO_ID = 16'h0000;
	localparam logic [15:0] LEN_MIN = 16'h0002;
	localparam logic [15:0] LEN_FIXED = 16'h0006;
	localparam logic [15:0] LEN_MULTI_MIN = 16'h0007;
	localparam logic [15:0] LEN_EXC = 16'h0003;
	localparam logic [15:0] LEN_ECHO = 16'h0006;
	localparam logic [15:0] LEN_READ_BASE = 16'h0003;
	localparam logic [15:0] ONE_W = 16'h0001;

	localparam logic [8:0] DATA_FIXED_LAST = 9'h003;
	localparam logic [8:0] DATA_BCNT_IDX = 9'h004;
	localparam logic [8:0] DIDX_RST = 9'h000;

	localparam logic [3:0] TX_IDX_RST = 4'h0;
	localparam logic [3:0] TX_IDX_FUNC = 4'h7;
	localparam logic [3:0] TX_IDX_PAY = 4'h8;
	localparam logic [3:0] TX_IDX_LAST = 4'hb;

	localparam logic [7:0] FC_READ_COILS = 8'h01;
	localparam logic [7:0] FC_READ_DISCRETES = 8'h02;
	localparam logic [7:0] FC_READ_HOLDING = 8'h03;
	localparam logic [7:0] FC_READ_INPUT = 8'h04;
	localparam logic [7:0] FC_WRITE_COIL = 8'h05;
	localparam logic [7:0] FC_WRITE_REG = 8'h06;
	localparam logic [7:0] FC_LOOPBACK = 8'h08;
	localparam logic [7:0] FC_WRITE_COILS = 8'h0f;
	localparam logic [7:0] FC_WRITE_REGS = 8'h10;
	localparam logic [7:0] FC_NONE = 8'h00;

	localparam logic [7:0] EXC_BIT = 8'h80;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
	localparam logic [7:0] EXC_DEV_FAIL = 8'h04;

	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [1:0] RST_CFG = 2'h0;
	localparam int FIFO_WIDTH = 9;
	localparam int FIFO_DEPTH = 2;

	// Zero is not a function code, so it falls out of every set
	function automatic logic func_server_ok(input logic [7:0] fc);
		func_server_ok = (fc == FC_READ_COILS) || (fc == FC_READ_DISCRETES) || (fc == FC_READ_HOLDING) ||
			(fc == FC_READ_INPUT) || (fc == FC_WRITE_COIL) || (fc == FC_WRITE_REG) ||
			(fc == FC_LOOPBACK) || (fc == FC_WRITE_COILS) || (fc == FC_WRITE_REGS);
	endfunction : func_server_ok

	function automatic logic func_client_ok(input logic [7:0] fc);
		func_client_ok = (fc == FC_READ_COILS) || (fc == FC_READ_DISCRETES) || (fc == FC_READ_HOLDING) ||
			(fc == FC_WRITE_REG) || (fc == FC_WRITE_COILS) || (fc == FC_WRITE_REGS);
	endfunction : func_client_ok

	function automatic logic func_is_multi(input logic [7:0] fc);
		func_is_multi = (fc == FC_WRITE_COILS) || (fc == FC_WRITE_REGS);
	endfunction : func_is_multi

	function automatic logic func_is_read(input logic [7:0] fc);
		func_is_read = (fc == FC_READ_COILS) || (fc == FC_READ_DISCRETES) ||
			(fc == FC_READ_HOLDING) || (fc == FC_READ_INPUT);
	endfunction : func_is_read

	function automatic space_t space_of(input logic [7:0] fc, input logic alt);
		case (fc)
			FC_READ_DISCRETES: space_of = SP_DISCRETES;
			FC_READ_HOLDING: space_of = alt ? SP_ANALOG_OUT : SP_HOLDING;
			FC_READ_INPUT: space_of = alt ? SP_ANALOG_IN : SP_INPUT_REGS;
			FC_WRITE_REG: space_of = SP_HOLDING;
			FC_WRITE_REGS: space_of = SP_HOLDING;
			default: space_of = SP_COILS;
		endcase
	endfunction : space_of

endpackage : modbus_pkg

// ---- frame_fifo.sv ----
// Purpose: Small shift-style FIFO; the head entry is a register.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Ready on the fill side depends only on the tail flag, never on out_ready.
`timescale 1ns/1ps
module frame_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] slot_q [DEPTH];
	logic full_q [DEPTH];
	logic push;
	logic pop;

	assign pop = full_q[0] && out_ready;
	assign in_ready = !full_q[DEPTH-1];
	assign push = in_valid && in_ready;
	assign out_valid = full_q[0];
	assign out_data = slot_q[0];

	for (genvar i = 0; i < DEPTH; i++)
	begin : g_slot
		logic above_full;
		logic [WIDTH-1:0] above_data;
		logic below_full;
		logic land;
		if (i == DEPTH - 1)
		begin : g_top
			assign above_full = 1'b0;
			assign above_data = {WIDTH{1'b0}};
		end
		else
		begin : g_mid
			assign above_full = full_q[i+1];
			assign above_data = slot_q[i+1];
		end
		if (i == 0)
		begin : g_bot
			assign below_full = 1'b1;
		end
		else
		begin : g_up
			assign below_full = full_q[i-1];
		end
		// With a pop the new word lands in the slot that shifts empty
		assign land = pop ? (full_q[i] && !above_full) : (!full_q[i] && below_full);

		always_ff @(posedge clk)
		begin
			if (!rst_n)
			begin
				full_q[i] <= 1'b0;
				slot_q[i] <= {WIDTH{1'b0}};
			end
			else if (push && land)
			begin
				full_q[i] <= 1'b1;
				slot_q[i] <= in_data;
			end
			else if (pop)
			begin
				full_q[i] <= above_full;
				slot_q[i] <= above_data;
			end
		end
	end
endmodule : frame_fifo

// ---- modbus_tcp_server_framer_sva.sv ----
// Purpose: Port-level assertions for the MODBUS TCP server framer.
// Assumes: One clock, synchronous active-low reset.
// Notes: Config pins pass a two-stage synchroniser, so pin checks wait for a settled pin.
`timescale 1ns/1ps
module framer_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Byte streams
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	// Memory side
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] cmd_func,
	input wire logic [15:0] cmd_addr,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic [7:0] wr_data,
	// Client filter
	input wire logic client_mode_pin,
	input wire logic cl_req_valid,
	input wire logic [7:0] cl_req_func,
	input wire logic cl_grant,
	input wire logic cl_refuse
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_RX_GAP: assert property (rx_valid && rx_ready |=> !rx_ready)
		else $error("rx_ready stayed high after a take");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("response byte changed while stalled");
	AST_CMD_HOLD: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_func) && $stable(cmd_addr))
		else $error("command changed before it was taken");
	AST_CMD_DROP: assert property (cmd_valid && cmd_ready |=> !cmd_valid)
		else $error("command stayed valid after it was taken");
	AST_CMD_CODE: assert property (cmd_valid |-> cmd_func inside {[8'h01:8'h06], 8'h0f, 8'h10})
		else $error("command carries a code that the memory side must not see");
	AST_WR_HOLD: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
		else $error("payload byte changed while stalled");
	AST_CL_ONE: assert property (cl_req_valid |=> cl_grant != cl_refuse)
		else $error("client filter did not answer exactly once");
	AST_CL_SET: assert property (cl_grant |-> $past(cl_req_valid) && $past(cl_req_func) inside {[8'h01:8'h03], 8'h06, 8'h0f, 8'h10})
		else $error("client filter granted a code outside the client set");
	AST_CL_SERVER: assert property ((!client_mode_pin) [*4] ##0 cl_req_valid |=> cl_refuse && !cl_grant)
		else $error("client request granted in server mode");
endmodule : framer_checker

bind modbus_tcp_server_framer framer_checker chk (.clk, .rst_n, .rx_valid, .rx_ready, .tx_valid, .tx_ready, .tx_data,
	.tx_last, .cmd_valid, .cmd_ready, .cmd_func, .cmd_addr, .wr_valid, .wr_ready, .wr_data, .client_mode_pin,
	.cl_req_valid, .cl_req_func, .cl_grant, .cl_refuse);

// ---- mem_model.sv ----
// Purpose: Behavioural memory side that serves framer commands.
// Assumes: Bench sets latency, error mode and read length before each frame.
// Notes: Read bytes count up from c0 so the bench can predict them.
`timescale 1ns/1ps
module mem_model
	import modbus_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command and completion
	input wire logic cmd_valid,
	output logic cmd_ready = 1'b0,
	input wire space_t cmd_space,
	input wire logic [15:0] cmd_addr,
	input wire logic [15:0] cmd_word,
	output logic done_valid = 1'b0,
	output logic done_error = 1'b0,
	output logic [7:0] done_excode = 8'h00,
	output logic [7:0] done_count = 8'h00,
	// Data streams
	output logic rd_valid = 1'b0,
	output logic [7:0] rd_data = 8'h5a,
	input wire logic rd_ready,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	output logic wr_ready = 1'b0,
	// Behaviour set by the bench
	input wire logic [7:0] lat,
	input wire logic err_en,
	input wire logic [7:0] excode,
	input wire logic [7:0] rd_n
);
	space_t seen_space;
	logic [15:0] seen_addr;
	logic [15:0] seen_word;
	logic [7:0] wr_last;
	int wr_cnt = 0;

	// One latency serves both ready and completion, so one knob makes it prompt or slow
	always
	begin
		@(posedge clk);
		if (rst_n && cmd_valid)
		begin
			repeat (lat)
				@(posedge clk);
			cmd_ready <= 1'b1;
			@(posedge clk);
			cmd_ready <= 1'b0;
			seen_space <= cmd_space;
			seen_addr <= cmd_addr;
			seen_word <= cmd_word;
			repeat (lat)
				@(posedge clk);
			done_valid <= 1'b1;
			done_error <= err_en;
			done_excode <= excode;
			done_count <= rd_n;
			@(posedge clk);
			done_valid <= 1'b0;
			done_count <= ~rd_n;
			for (int i = 0; i < rd_n; i++)
			begin
				rd_valid <= 1'b1;
				rd_data <= 8'hc0 + 8'(i);
				@(posedge clk);
				while (!rd_ready)
					@(posedge clk);
			end
			rd_valid <= 1'b0;
			rd_data <= ~rd_data;
		end
	end

	// Ready every other cycle so the payload path has to wait
	always @(posedge clk)
	begin
		wr_ready <= rst_n && !wr_ready;
		if (rst_n && wr_valid && wr_ready)
		begin
			wr_cnt <= wr_cnt + 1;
			wr_last <= wr_data;
		end
	end
endmodule : mem_model

// ---- test_modbus_tcp_server_framer.sv ----
// Purpose: Self-checking bench for the MODBUS TCP server framer.
// Assumes: Bench acts as network client; mem_model serves commands.
// Notes: Inputs change on the falling edge; responses are collected by a monitor.
`timescale 1ns/1ps
module test_modbus_tcp_server_framer
	import modbus_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic tx_ready = 1'b1;
	logic client_mode_pin = 1'b0;
	logic alt_addr_pin = 1'b0;
	logic cl_req_valid = 1'b0;
	logic [7:0] cl_req_func = 8'h00;
	logic rx_ready, tx_valid, tx_last, cmd_valid, cmd_ready, wr_valid, wr_ready, done_valid, done_error;
	logic rd_valid, rd_ready, cl_grant, cl_refuse;
	logic [7:0] tx_data, cmd_func, cmd_unit, wr_data, done_excode, done_count, rd_data;
	logic [15:0] cmd_addr, cmd_word;
	space_t cmd_space;
	logic [7:0] lat = 8'h01, excode = 8'h00, rd_n = 8'h00, unit_q = 8'h11;
	logic err_en = 1'b0, stall_en = 1'b0, rsp_done = 1'b0;
	logic [2:0] stall_cnt = 3'h0;
	logic [15:0] tid_q = 16'h0000;
	logic [7:0] rsp[$];
	int failures = 0, total_checks = 0;

	always #4 clk = ~clk;

	modbus_tcp_server_framer dut (.clk, .rst_n, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_last,
		.tx_ready, .client_mode_pin, .alt_addr_pin, .cmd_valid, .cmd_ready, .cmd_func, .cmd_space, .cmd_addr,
		.cmd_word, .cmd_unit, .wr_valid, .wr_data, .wr_ready, .done_valid, .done_error, .done_excode, .done_count,
		.rd_valid, .rd_data, .rd_ready, .cl_req_valid, .cl_req_func, .cl_grant, .cl_refuse);
	mem_model mem (.clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_space, .cmd_addr, .cmd_word, .done_valid, .done_error,
		.done_excode, .done_count, .rd_valid, .rd_data, .rd_ready, .wr_valid, .wr_data, .wr_ready, .lat, .err_en,
		.excode, .rd_n);

	always @(posedge clk)
	begin
		if (tx_valid && tx_ready)
		begin
			rsp.push_back(tx_data);
			if (tx_last)
				rsp_done <= 1'b1;
		end
	end

	// Sparse ready lets the two-entry buffer fill and refuse
	always @(negedge clk)
	begin
		stall_cnt <= stall_cnt + 3'h1;
		tx_ready <= !stall_en || (stall_cnt == 3'h0);
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic send_byte(input logic [7:0] b);
		rx_data = b;
		rx_valid = 1'b1;
		@(posedge clk);
		for (int n = 0; n < 100 && rx_ready !== 1'b1; n++)
			@(posedge clk);
		// A byte that is never taken counts against the run
		if (rx_ready !== 1'b1)
			failures++;
		@(negedge clk);
	endtask : send_byte

	task automatic send_req(input logic [7:0] fc, input logic [15:0] pid, input logic [7:0] d[$]);
		logic [15:0] len;
		logic [7:0] f[$];
		len = 16'(d.size() + 2);
		tid_q = tid_q + 16'h0123;
		unit_q = unit_q + 8'h07;
		f = {tid_q[15:8], tid_q[7:0], pid[15:8], pid[7:0], len[15:8], len[7:0], unit_q, fc};
		foreach (d[i])
			f.push_back(d[i]);
		rsp.delete();
		rsp_done = 1'b0;
		foreach (f[i])
			send_byte(f[i]);
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask : send_req

	task automatic expect_rsp(input logic [7:0] fc, input logic [7:0] p[$]);
		logic [15:0] len;
		logic [7:0] e[$];
		len = 16'(p.size() + 2);
		e = {tid_q[15:8], tid_q[7:0], 8'h00, 8'h00, len[15:8], len[7:0], unit_q, fc};
		foreach (p[i])
			e.push_back(p[i]);
		for (int n = 0; n < 3000 && !rsp_done; n++)
			@(posedge clk);
		@(negedge clk);
		check("rsp_len", 16'(e.size()), 16'(rsp.size()));
		foreach (e[i])
			check("rsp_byte", e[i], i < rsp.size() ? rsp[i] : ~e[i]);
	endtask : expect_rsp

	task automatic do_fixed(input logic [7:0] fc, input logic alt, input space_t sp);
		alt_addr_pin = alt;
		rd_n = (fc < 8'h05) ? 8'h02 : 8'h00;
		repeat (4)
			@(negedge clk);
		send_req(fc, 16'h0000, {8'h01, 8'h2a, 8'h00, 8'h02});
		if (rd_n != 8'h00)
			expect_rsp(fc, {8'h02, 8'hc0, 8'hc1});
		else
			expect_rsp(fc, {8'h01, 8'h2a, 8'h00, 8'h02});
		check("cmd_unit", 16'(unit_q), 16'(cmd_unit));
		check("cmd_func", 16'(fc), 16'(cmd_func));
		if (fc != FC_LOOPBACK)
		begin
			check("cmd_space", 16'(sp), 16'(mem.seen_space));
			check("cmd_addr", 16'h012a, mem.seen_addr);
		end
	endtask : do_fixed

	task automatic t_codes();
		do_fixed(FC_READ_COILS, 1'b0, SP_COILS);
		do_fixed(FC_READ_DISCRETES, 1'b0, SP_DISCRETES);
		do_fixed(FC_READ_HOLDING, 1'b0, SP_HOLDING);
		do_fixed(FC_READ_HOLDING, 1'b1, SP_ANALOG_OUT);
		do_fixed(FC_READ_INPUT, 1'b0, SP_INPUT_REGS);
		do_fixed(FC_READ_INPUT, 1'b1, SP_ANALOG_IN);
		do_fixed(FC_WRITE_COIL, 1'b0, SP_COILS);
		do_fixed(FC_WRITE_REG, 1'b0, SP_HOLDING);
		do_fixed(FC_LOOPBACK, 1'b0, SP_COILS);
		alt_addr_pin = 1'b0;
		$display("test codes done");
	endtask : t_codes

	task automatic t_multi();
		int w0;
		w0 = mem.wr_cnt;
		lat = 8'h06;
		stall_en = 1'b1;
		rd_n = 8'h00;
		send_req(FC_WRITE_REGS, 16'h0000, {8'h00, 8'h10, 8'h00, 8'h02, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44});
		expect_rsp(FC_WRITE_REGS, {8'h00, 8'h10, 8'h00, 8'h02});
		check("wr_count", 16'(w0 + 4), 16'(mem.wr_cnt));
		check("wr_last", 16'h0044, mem.wr_last);
		check("cmd_word", 16'h0002, mem.seen_word);
		send_req(FC_WRITE_COILS, 16'h0000, {8'h00, 8'h05, 8'h00, 8'h08, 8'h01, 8'hff});
		expect_rsp(FC_WRITE_COILS, {8'h00, 8'h05, 8'h00, 8'h08});
		check("wr_last", 16'h00ff, mem.wr_last);
		rd_n = 8'h06;
		send_req(FC_READ_HOLDING, 16'h0000, {8'h00, 8'h00, 8'h00, 8'h03});
		expect_rsp(FC_READ_HOLDING, {8'h06, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5});
		stall_en = 1'b0;
		lat = 8'h01;
		$display("test multi done");
	endtask : t_multi

	task automatic t_errors();
		logic [7:0] d4[$];
		d4 = {8'h00, 8'h01, 8'h00, 8'h05};
		rd_n = 8'h00;
		err_en = 1'b1;
		excode = 8'h02;
		send_req(FC_WRITE_REG, 16'h0000, d4);
		expect_rsp(8'h86, {8'h02});
		excode = 8'h00;
		send_req(FC_READ_INPUT, 16'h0000, d4);
		expect_rsp(8'h84, {8'h04});
		err_en = 1'b0;
		send_req(8'h2b, 16'h0000, d4);
		expect_rsp(8'hab, {8'h01});
		send_req(8'h00, 16'h0000, d4);
		expect_rsp(8'h80, {8'h01});
		send_req(FC_WRITE_REG, 16'h0000, {8'h00, 8'h01, 8'h00});
		expect_rsp(8'h86, {8'h03});
		send_req(FC_WRITE_REGS, 16'h0000, {8'h00, 8'h10, 8'h00, 8'h01, 8'h03, 8'haa, 8'hbb});
		expect_rsp(8'h90, {8'h03});
		send_req(FC_WRITE_REG, 16'h0001, d4);
		send_req(FC_WRITE_REG, 16'h0000, d4);
		expect_rsp(FC_WRITE_REG, d4);
		$display("test errors done");
	endtask : t_errors

	task automatic t_client();
		logic [7:0] fcs[$];
		logic g;
		fcs = {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0f, 8'h10, 8'h2b};
		client_mode_pin = 1'b1;
		repeat (4)
			@(negedge clk);
		foreach (fcs[i])
		begin
			cl_req_valid = 1'b1;
			cl_req_func = fcs[i];
			@(negedge clk);
			g = fcs[i] inside {8'h01, 8'h02, 8'h03, 8'h06, 8'h0f, 8'h10};
			check("cl_grant", 16'(g), 16'(cl_grant));
			check("cl_refuse", 16'(!g), 16'(cl_refuse));
		end
		client_mode_pin = 1'b0;
		cl_req_func = 8'h01;
		repeat (5)
			@(negedge clk);
		check("cl_refuse", 16'h0001, 16'(cl_refuse));
		cl_req_valid = 1'b0;
		$display("test client done");
	endtask : t_client

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	initial
	begin
		repeat (3)
			@(negedge clk);
		rst_n = 1'b1;
		repeat (4)
			@(negedge clk);
		t_codes();
		t_multi();
		t_errors();
		t_client();
		complete_run();
	end

	// Whole run needs a few thousand cycles; this leaves a wide margin
	initial
	begin
		repeat (60000)
			@(posedge clk);
		failures++;
		complete_run();
	end
endmodule : test_modbus_tcp_server_framer
